// ===== include/anadv_pkg.sv
/*
  Constants, field layout and carriers for the auto-negotiation
  advertisement register bank.
  Assumes a 16-bit management register space with 5-bit addresses.
*/
package anadv_pkg;

  // management register space
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] ADV_ADDR = 5'h04;
  localparam logic [15:0] RDATA_IDLE = 16'h0000;

  // selector codes
  localparam int unsigned SEL_W = 5;
  localparam logic [4:0] SEL_ETHERNET = 5'h01;
  localparam logic [4:0] SEL_ISLAN = 5'h02;
  localparam logic [4:0] SEL_RSVD_LO = 5'h00;
  localparam logic [4:0] SEL_RSVD_HI = 5'h1F;

  // number of configuration pins caught at hardware reset
  localparam int unsigned STRAP_W = 5;

  // reset values of the fixed fields
  localparam logic ZERO_BIT = 1'b0;
  localparam logic [4:0] SEL_RESET = SEL_ETHERNET;

  // advertisement word, bit 15 first
  typedef struct packed {
    logic next_page;
    logic rsvd14;
    logic remote_fault;
    logic rsvd12;
    logic asym_pause;
    logic pause;
    logic t4;
    logic tx_fd;
    logic tx_hd;
    logic t10_fd;
    logic t10_hd;
    logic [4:0] selector;
  } adv_word_s;

  // configuration pins that seed the ability bits
  typedef struct packed {
    logic pause;
    logic tx_fd;
    logic tx_hd;
    logic t10_fd;
    logic t10_hd;
  } strap_s;

  // one management request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // partner base page as seen by the arbitration logic
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } partner_page_s;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_RUN
  } init_state_e;

endpackage

// ===== logic/autoneg_advertisement_reg.sv
/*
  Auto-negotiation advertisement register with pin-seeded ability
  bits, software reset restore and the selector check that gates
  completion.
  Assumes a management master on mclk using one-cycle strobes, and
  an arbitration engine that pulses exchange_start per exchange.
  Configuration pins must stay still for the whole hardware reset;
  they pass a three-stage filter and are not read again after it.
  Software reset arrives as a pulse from the control register side.
*/
// Functional notes
// (RL1) bit 15 read/write next-page ability, resets to zero
// (RL2) bits 14 and 12 read zero; software writes zero there
// (RL3) bit 13 read/write remote fault advertisement, resets to zero
// (RL4) bit 11 read/write asymmetric pause ability, resets to zero
// (RL5) bit 10 read/write symmetric pause ability
// (RL6) bit 9 writable 100BASE-T4 advertisement, resets to zero
// (RL7) bit 8 read/write 100BASE-TX full-duplex ability
// (RL8) bit 7 read/write 100BASE-TX half-duplex ability
// (RL9) bit 6 read/write 10BASE-T full-duplex ability
// (RL10) bit 5 read/write 10BASE-T half-duplex ability
// (RL11) bits 4:0 selector field, resets to Ethernet code
// (RL12) any 5-bit selector value written is stored unchanged
// (RL13) completion allowed only when partner selector equals local one
// (RL14) software avoids reserved or unspecified selector codes
// (RL15) pause and bits 8:5 reset from configuration pins
// (RL16) pins caught at hardware reset only; soft reset restores them
// (RL17) written value used at next exchange; reads return all 16 bits
`timescale 1ns/1ps
module autoneg_advertisement_reg (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic soft_reset,
  input wire anadv_pkg::reg_req_s bus_req,
  output logic [anadv_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [anadv_pkg::STRAP_W-1:0] strap_pins,
  input wire logic exchange_start,
  input wire anadv_pkg::partner_page_s partner_page,
  output logic [anadv_pkg::DATA_W-1:0] adv_tx_word,
  output logic adv_pending,
  output logic sel_unusual,
  output logic sel_match,
  output logic sel_seen,
  output logic an_complete_ok,
  output logic init_done,
  output anadv_pkg::strap_s pin_latched_on_hw_reset
);

  // ---- declarations
  anadv_pkg::adv_word_s adv_r;
  anadv_pkg::adv_word_s adv_nxt;
  anadv_pkg::adv_word_s tx_r;
  anadv_pkg::adv_word_s tx_nxt;
  anadv_pkg::strap_s latch_r;
  anadv_pkg::init_state_e state_r;
  anadv_pkg::init_state_e state_nxt;
  logic [anadv_pkg::DATA_W-1:0] rdata_r;
  logic [anadv_pkg::DATA_W-1:0] rdata_nxt;
  logic pending_r;
  logic pending_nxt;
  logic unusual_r;
  logic complete_r;
  logic init_done_r;

  wire logic [anadv_pkg::STRAP_W-1:0] pin_filt;
  wire anadv_pkg::strap_s pin_now;
  wire logic wr_hit;
  wire logic rd_hit;
  wire logic restore;
  wire anadv_pkg::adv_word_s adv_default;
  wire anadv_pkg::adv_word_s adv_written;
  wire logic match_w;
  wire logic seen_w;
  wire logic in_load;
  wire logic in_run;

  // ---- address decode shared by the read and the write path
  function automatic logic addr_hit(input logic [anadv_pkg::ADDR_W-1:0] a);
    addr_hit = (a == anadv_pkg::ADV_ADDR);
  endfunction

  // ---- selector codes that the partner is not meant to receive
  function automatic logic sel_odd(input logic [anadv_pkg::SEL_W-1:0] s);
    sel_odd = (s != anadv_pkg::SEL_ETHERNET) && (s != anadv_pkg::SEL_ISLAN);
  endfunction

  // ---- build the reset image from the latched pin values
  function automatic anadv_pkg::adv_word_s make_default(
    input anadv_pkg::strap_s p
  );
    anadv_pkg::adv_word_s w;
    w = '0;
    w.next_page = anadv_pkg::ZERO_BIT; // [RL1]
    w.rsvd14 = anadv_pkg::ZERO_BIT; // [RL2]
    w.remote_fault = anadv_pkg::ZERO_BIT; // [RL3]
    w.rsvd12 = anadv_pkg::ZERO_BIT; // [RL2]
    w.asym_pause = anadv_pkg::ZERO_BIT; // [RL4]
    w.pause = p.pause; // [RL15]
    w.t4 = anadv_pkg::ZERO_BIT; // [RL6]
    w.tx_fd = p.tx_fd; // [RL15]
    w.tx_hd = p.tx_hd; // [RL15]
    w.t10_fd = p.t10_fd; // [RL15]
    w.t10_hd = p.t10_hd; // [RL15]
    w.selector = anadv_pkg::SEL_RESET; // [RL11]
    make_default = w;
  endfunction

  // ---- merge a management write, reserved bits forced to zero
  function automatic anadv_pkg::adv_word_s make_written(
    input logic [anadv_pkg::DATA_W-1:0] d
  );
    anadv_pkg::adv_word_s in;
    anadv_pkg::adv_word_s w;
    in = anadv_pkg::adv_word_s'(d);
    w = in;
    w.next_page = in.next_page; // [RL1]
    w.rsvd14 = anadv_pkg::ZERO_BIT; // [RL2]
    w.remote_fault = in.remote_fault; // [RL3]
    w.rsvd12 = anadv_pkg::ZERO_BIT; // [RL2]
    w.asym_pause = in.asym_pause; // [RL4]
    w.pause = in.pause; // [RL5]
    w.t4 = in.t4; // [RL6]
    w.tx_fd = in.tx_fd; // [RL7]
    w.tx_hd = in.tx_hd; // [RL8]
    w.t10_fd = in.t10_fd; // [RL9]
    w.t10_hd = in.t10_hd; // [RL10]
    w.selector = in.selector; // [RL12]
    make_written = w;
  endfunction

  // ---- configuration pins come from outside the clock domain
  strap_sync u_strap_sync (
    .mclk(mclk),
    .pin_in(strap_pins),
    .pin_filt(pin_filt)
  );

  assign pin_now = anadv_pkg::strap_s'(pin_filt);

  // ---- init state decode, shared by the restore, tx and status paths
  assign in_load = (state_r == anadv_pkg::ST_LOAD);
  assign in_run = (state_r == anadv_pkg::ST_RUN);

  // ---- decode of strobes and restore sources
  assign wr_hit = bus_req.wr && addr_hit(bus_req.addr);
  assign rd_hit = bus_req.rd && addr_hit(bus_req.addr);
  assign restore = soft_reset || in_load;
  assign adv_default = make_default(latch_r);
  assign adv_written = make_written(bus_req.wdata);

  // ---- pins are sampled only while hardware reset is held
  // the filter needs a few cycles, so reset must outlast pin settling
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      latch_r <= pin_now; // [RL16]
    end
  end

  // ---- first cycle after hardware reset loads the pin image
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      anadv_pkg::ST_LOAD:
      begin
        state_nxt = anadv_pkg::ST_RUN;
      end
      anadv_pkg::ST_RUN:
      begin
        state_nxt = anadv_pkg::ST_RUN;
      end
      default:
      begin
        state_nxt = anadv_pkg::ST_LOAD;
      end
    endcase
  end

  // ---- register value: restore beats write, write beats hold
  // a write that lands in a restore cycle is lost and must be repeated
  always_comb
  begin
    adv_nxt = adv_r;
    if (restore)
    begin
      adv_nxt = adv_default; // [RL16]
    end
    else if (wr_hit)
    begin
      adv_nxt = adv_written; // [RL12]
    end
  end

  // ---- the word sent on the link changes only in the load cycle and at an exchange start
  // a soft reset leaves the word on the link alone until then
  always_comb
  begin
    tx_nxt = tx_r;
    if (in_load)
    begin
      tx_nxt = adv_default;
    end
    else if (exchange_start)
    begin
      tx_nxt = adv_r; // [RL17]
    end
  end

  // ---- a write since the last exchange marks the word as pending;
  // a write in the start cycle itself stays pending, while a restore
  // throws the write away and so clears the mark as well
  always_comb
  begin
    pending_nxt = pending_r;
    if (restore)
    begin
      pending_nxt = 1'b0;
    end
    else if (wr_hit)
    begin
      pending_nxt = 1'b1; // [RL17]
    end
    else if (exchange_start)
    begin
      pending_nxt = 1'b0;
    end
  end

  // ---- read data stands only in the cycle after the strobe
  // a read right after a write already sees the new word
  always_comb
  begin
    rdata_nxt = anadv_pkg::RDATA_IDLE;
    if (rd_hit)
    begin
      rdata_nxt = adv_r; // [RL17]
    end
  end

  // ---- state, register and read-back flops
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r <= anadv_pkg::ST_LOAD;
      adv_r <= '0;
      tx_r <= '0;
      pending_r <= 1'b0;
      rdata_r <= anadv_pkg::RDATA_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      adv_r <= adv_nxt;
      tx_r <= tx_nxt;
      pending_r <= pending_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---- partner selector check against the word in use
  // a page that arrives with exchange_start is judged against the old word
  selector_match u_selector_match (
    .mclk(mclk),
    .nrst(nrst),
    .clear(exchange_start),
    .local_sel(tx_r.selector),
    .partner(partner_page),
    .match(match_w),
    .seen(seen_w)
  );

  // ---- status flags for software and the arbitration engine
  // the selector flag is held low in the load cycle, while the register
  // still holds its reset zeroes, so no false warning follows reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      unusual_r <= 1'b0;
      complete_r <= 1'b0;
      init_done_r <= 1'b0;
    end
    else
    begin
      unusual_r <= in_run && sel_odd(adv_r.selector); // [RL14]
      complete_r <= match_w && seen_w; // [RL13]
      init_done_r <= in_run;
    end
  end

  // ---- outputs, each from a flop
  assign bus_rdata = rdata_r;
  assign adv_tx_word = tx_r;
  assign adv_pending = pending_r;
  assign sel_unusual = unusual_r;
  assign sel_match = match_w;
  assign sel_seen = seen_w;
  assign an_complete_ok = complete_r;
  assign init_done = init_done_r;
  assign pin_latched_on_hw_reset = latch_r;

endmodule

// ===== logic/selector_match.sv
/*
  Compares the partner's received selector with the locally
  programmed one.
  Assumes partner pages arrive as one-cycle valid pulses on mclk.
*/
`timescale 1ns/1ps
module selector_match (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic [anadv_pkg::SEL_W-1:0] local_sel,
  input wire anadv_pkg::partner_page_s partner,
  output logic match,
  output logic seen
);

  logic match_r;
  logic seen_r;
  wire logic [anadv_pkg::SEL_W-1:0] partner_sel;
  wire logic same_sel;

  // partner selector sits in the low field of the base page
  assign partner_sel = partner.word[anadv_pkg::SEL_W-1:0];
  assign same_sel = (partner_sel == local_sel);

  // a new page wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      match_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else if (partner.valid)
    begin
      match_r <= same_sel; // [RL13]
      seen_r <= 1'b1;
    end
    else if (clear)
    begin
      match_r <= 1'b0;
      seen_r <= 1'b0;
    end
  end

  assign match = match_r;
  assign seen = seen_r;

endmodule

// ===== logic/strap_sync.sv
/*
  Three-stage synchroniser with agreement filter for the
  configuration pins.
  Assumes pins change slowly compared with mclk.
*/
`timescale 1ns/1ps
module strap_sync (
  input wire logic mclk,
  input wire logic [anadv_pkg::STRAP_W-1:0] pin_in,
  output logic [anadv_pkg::STRAP_W-1:0] pin_filt
);

  logic [anadv_pkg::STRAP_W-1:0] s1_r;
  logic [anadv_pkg::STRAP_W-1:0] s2_r;
  logic [anadv_pkg::STRAP_W-1:0] s3_r;
  logic [anadv_pkg::STRAP_W-1:0] filt_r;

  // per pin: three flops, value taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < anadv_pkg::STRAP_W; gi++)
    begin : g_pin
      always_ff @(posedge mclk)
      begin
        s1_r[gi] <= pin_in[gi];
        s2_r[gi] <= s1_r[gi];
        s3_r[gi] <= s2_r[gi];
        if (s2_r[gi] == s3_r[gi])
        begin
          filt_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  assign pin_filt = filt_r;

endmodule

// ===== tb/autoneg_advertisement_reg_assertions.sv
/*
  Port-level checks on the advertisement register bank.
  Assumes one clock, mclk, and synchronous active-low nrst.
*/
`timescale 1ns/1ps
module autoneg_advertisement_reg_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic soft_reset,
  input wire anadv_pkg::reg_req_s bus_req,
  input wire logic [anadv_pkg::DATA_W-1:0] bus_rdata,
  input wire logic exchange_start,
  input wire anadv_pkg::partner_page_s partner_page,
  input wire logic [anadv_pkg::DATA_W-1:0] adv_tx_word,
  input wire logic adv_pending,
  input wire logic sel_match,
  input wire logic sel_seen,
  input wire logic an_complete_ok,
  input wire logic init_done,
  input wire anadv_pkg::strap_s pin_latched_on_hw_reset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // read data stands only in the cycle after a read strobe
  chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (
    bus_req.rd && bus_req.addr != anadv_pkg::ADV_ADDR |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_reserved_zero: assert property (
    bus_req.rd |=> bus_rdata[14] == 1'b0 && bus_rdata[12] == 1'b0)
    else $error("reserved bit read as one");
  // a write followed at once by a read returns the word, reserved bits cleared
  chk_write_readback: assert property (
    bus_req.wr && bus_req.addr == anadv_pkg::ADV_ADDR && init_done && !soft_reset
    ##1 bus_req.rd && bus_req.addr == anadv_pkg::ADV_ADDR
    |=> bus_rdata == ($past(bus_req.wdata, 2) & 16'hAFFF))
    else $error("read back differs from write");
  // software reset restores the pin values caught at hardware reset
  chk_soft_restore: assert property (
    soft_reset ##1 bus_req.rd && bus_req.addr == anadv_pkg::ADV_ADDR
    |=> bus_rdata == {5'h00, pin_latched_on_hw_reset[4], 1'b0,
                      pin_latched_on_hw_reset[3:0], anadv_pkg::SEL_RESET})
    else $error("soft reset restore wrong");
  chk_latch_hold: assert property (
    $past(nrst) |-> $stable(pin_latched_on_hw_reset))
    else $error("pin latch changed outside reset");
  chk_pending_set: assert property (
    bus_req.wr && bus_req.addr == anadv_pkg::ADV_ADDR && init_done && !soft_reset
    |=> adv_pending)
    else $error("pending not set by write");
  chk_pending_clear: assert property (
    exchange_start && !bus_req.wr |=> !adv_pending)
    else $error("pending not cleared by exchange");
  // partner page compared with the selector in use
  chk_match_result: assert property (
    partner_page.valid && !exchange_start |=> sel_seen &&
    sel_match == ($past(partner_page.word[4:0]) == $past(adv_tx_word[4:0])))
    else $error("selector match wrong");
  chk_complete_gate: assert property (
    $past(nrst) |-> an_complete_ok == $past(sel_match && sel_seen))
    else $error("completion not gated by match");
endmodule

bind autoneg_advertisement_reg autoneg_advertisement_reg_assertions chk_u (
  .mclk(mclk),
  .nrst(nrst),
  .soft_reset(soft_reset),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .exchange_start(exchange_start),
  .partner_page(partner_page),
  .adv_tx_word(adv_tx_word),
  .adv_pending(adv_pending),
  .sel_match(sel_match),
  .sel_seen(sel_seen),
  .an_complete_ok(an_complete_ok),
  .init_done(init_done),
  .pin_latched_on_hw_reset(pin_latched_on_hw_reset)
);

// ===== tb/autoneg_advertisement_reg_tb.sv
/*
  Self-checking bench for the advertisement register bank.
  Assumes the design, the partner model and the checker are compiled.
*/
`timescale 1ns/1ps
module autoneg_advertisement_reg_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic soft_reset = 1'b0;
  anadv_pkg::reg_req_s req = '0;
  logic [4:0] pins = 5'h16;
  logic xs = 1'b0;
  logic send = 1'b0;
  logic [4:0] psel = 5'h01;
  logic [3:0] gap = 4'h0;
  anadv_pkg::partner_page_s page;
  anadv_pkg::strap_s latched;
  logic [15:0] bus_rdata;
  logic [15:0] tx_word;
  logic pend;
  logic ok;
  logic odd;
  logic idone;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  autoneg_advertisement_reg dut_u (.mclk(mclk), .nrst(nrst), .soft_reset(soft_reset),
    .bus_req(req), .bus_rdata(bus_rdata), .strap_pins(pins), .exchange_start(xs),
    .partner_page(page), .adv_tx_word(tx_word), .adv_pending(pend), .sel_unusual(odd),
    .sel_match(), .sel_seen(), .an_complete_ok(ok), .init_done(idone),
    .pin_latched_on_hw_reset(latched));
  partner_link_model peer_u (.mclk(mclk), .send(send), .sel(psel), .gap(gap), .page(page));

  // clock and hang guard
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      $display("BAD %0t run timed out", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] dflt(input logic [4:0] s);
    return {5'h00, s[4], 1'b0, s[3:0], anadv_pkg::SEL_RESET};
  endfunction

  task automatic hw_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  // write, then read back in the very next cycle
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    req.addr <= anadv_pkg::ADV_ADDR;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  task automatic t_reset();
    rd(anadv_pkg::ADV_ADDR, dflt(pins));
    chk({11'h000, latched}, {11'h000, pins});
    chk(tx_word, dflt(pins));
    chk({15'h0000, idone}, 16'h0001);
    chk({15'h0000, odd}, 16'h0000);
  endtask

  task automatic t_rw();
    logic [15:0] pat[6] = '{16'hFFFF, 16'h0000, 16'h5A1F, 16'hA5E0, 16'h0842, 16'h0300};
    // bit set where the pattern's selector is neither defined code
    logic [5:0] odd_exp = 6'h2F;
    foreach (pat[i])
    begin
      wr_rd(anadv_pkg::ADV_ADDR, pat[i], pat[i] & 16'hAFFF);
      chk({15'h0000, odd}, {15'h0000, odd_exp[i]});
    end
    wr_rd(5'h05, 16'hFFFF, 16'h0300);
    rd(5'h05, 16'h0000);
  endtask

  task automatic t_soft();
    wr_rd(anadv_pkg::ADV_ADDR, 16'hFFFF, 16'hAFFF);
    // new pin values reach the filter before the soft reset
    @(posedge mclk);
    pins <= 5'h09;
    repeat (6) @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    req.rd <= 1'b1;
    req.addr <= anadv_pkg::ADV_ADDR;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(bus_rdata, dflt(5'h16));
    chk({15'h0000, pend}, 16'h0000);
    hw_reset();
    rd(anadv_pkg::ADV_ADDR, dflt(5'h09));
  endtask

  task automatic t_neg(input logic [4:0] s, input logic [3:0] g, input logic exp);
    wr_rd(anadv_pkg::ADV_ADDR, 16'h01E1, 16'h01E1);
    @(posedge mclk);
    xs <= 1'b1;
    psel <= s;
    gap <= g;
    @(posedge mclk);
    xs <= 1'b0;
    send <= 1'b1;
    #1 chk(tx_word, 16'h01E1);
    chk({15'h0000, pend}, 16'h0000);
    @(posedge mclk);
    send <= 1'b0;
    repeat (g + 5) @(posedge mclk);
    #1 chk({15'h0000, ok}, {15'h0000, exp});
  endtask

  initial
  begin
    hw_reset();
    t_reset();
    t_rw();
    t_soft();
    t_neg(5'h01, 4'h0, 1'b1);
    t_neg(5'h02, 4'h7, 1'b0);
    t_neg(5'h01, 4'hA, 1'b1);
    stop_test();
  end
endmodule

// ===== tb/partner_link_model.sv
/*
  Behavioural link partner: sends one base page per request.
  Assumes requests on mclk; gap sets how slowly it answers.
*/
`timescale 1ns/1ps
module partner_link_model (
  input wire logic mclk,
  input wire logic send,
  input wire logic [4:0] sel,
  input wire logic [3:0] gap,
  output anadv_pkg::partner_page_s page
);
  logic [3:0] cnt_r = 4'h0;
  logic busy_r = 1'b0;
  initial page = '0;
  // word toggles between pages so a stale value never looks valid
  always @(posedge mclk)
  begin
    page.valid <= 1'b0;
    page.word <= ~page.word;
    if (send)
    begin
      busy_r <= 1'b1;
      cnt_r <= gap;
    end
    else if (busy_r && cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
    end
    else if (busy_r)
    begin
      busy_r <= 1'b0;
      page.valid <= 1'b1;
      page.word <= {11'h421, sel};  // selector in bits 4:0
    end
  end
endmodule
